// file: src/cpurf_register_file.v
`timescale 1ns/100ps
`include "cpurf_defines.vh"
// Overview of operation
// [RULE_01] Accumulator: 8-bit operand and result register.
// [RULE_02] Index register: 8-bit, indexed address or storage.
// [RULE_03] 16-bit counter holds next fetch address.
// [RULE_04] Reset or reinit sets stack pointer top.
// [RULE_05] Push decrements, pull increments stack pointer.
// [RULE_06] Stack address upper bits fixed constant pattern.
// [RULE_07] Only six low pointer bits vary.
// [RULE_08] Overflow past 64 wraps silently.
// [RULE_09] Call uses two, interrupt five locations.
// [RULE_10] Flags register: five bits, one mask.
// [RULE_11] Half carry set on bit-3 carry for adds.
// [RULE_12] Mask set blocks all maskable interrupts.
// [RULE_13] Masked requests held pending until unmasked.
// [RULE_14] Negative flag reflects negative result.
// [RULE_15] Zero flag reflects zero result.
// [RULE_16] Carry flag reflects carry or borrow out.
// [RULE_17] Bit-test branches, shifts, rotates update carry.
// [RULE_18] Interrupt entry stacks and masks; return restores.
// [RULE_19] Accumulator, index, result flags reset undefined.
module cpurf_register_file #(
  parameter DW = `CPURF_DATA_W,
  parameter AW = `CPURF_ADDR_W,
  parameter SW = `CPURF_SP_W,
  parameter NI = `CPURF_IRQ_N
) (
  input  wire          clk,          // Core clock.
  input  wire          reset,        // Synchronous reset, active high.
  input  wire          accLoad,      // Load accumulator from resultData.
  input  wire          idxLoad,      // Load index register from resultData.
  input  wire [DW-1:0] resultData,   // Result from the arithmetic unit.
  input  wire          pcLoad,       // Load fetch address counter.
  input  wire          pcIncr,       // Advance fetch address by one.
  input  wire [AW-1:0] pcData,       // New fetch address.
  input  wire [1:0]    stackOp,      // None, push, pull or reinit.
  input  wire          flagsLoad,    // Restore all flags from flagsData.
  input  wire [`CPURF_FLAGS_W-1:0] flagsData, // Flags popped on interrupt return.
  input  wire          updNz,        // Update negative and zero from result.
  input  wire          updH,         // Add operation: update half carry.
  input  wire [DW-1:0] opA,          // First add operand.
  input  wire [DW-1:0] opB,          // Second add operand.
  input  wire          updC,         // Update carry from carryOut.
  input  wire          carryOut,     // Carry, borrow, shifted or tested bit.
  input  wire          maskSet,      // Set the interrupt mask.
  input  wire          maskClear,    // Clear the interrupt mask.
  input  wire          intEntry,     // Interrupt entry: set mask.
  input  wire [NI-1:0] irqReq,       // Maskable interrupt requests.
  input  wire [NI-1:0] irqTaken,     // Clears the pending request.
  output reg  [DW-1:0] accumulator,  // Accumulator.
  output reg  [DW-1:0] indexReg,     // Index register.
  output reg  [AW-1:0] fetch_address_counter, // Next fetch address.
  output reg  [AW-1:0] stackAddr,    // Stack memory address.
  output reg  [`CPURF_FLAGS_W-1:0] condition_flags_reg, // Condition flags.
  output reg  [NI-1:0] irqPending,   // Held requests, mask ignored.
  output reg  [NI-1:0] irqService    // Requests allowed to be serviced.
);
  reg  [SW-1:0] stack_ptr;
  reg  [SW-1:0] next_stack_ptr;
  wire [NI-1:0] pendRaw;
  wire          halfCarry;
  wire          negative;
  wire          zero;

  // Shared carry-in is the current carry flag so add-with-carry is covered.
  cpurf_flag_calc #(
    .W(DW)
  ) u_flags (
    .opA       (opA),
    .opB       (opB),
    .carryIn   (condition_flags_reg[`CPURF_FLAG_C]),
    .result    (resultData),
    .halfCarry (halfCarry),
    .negative  (negative),
    .zero      (zero)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NI; gi = gi + 1) begin : g_pend
      cpurf_pend_latch u_pend (
        .clk     (clk),
        .reset   (reset),
        .request (irqReq[gi]),
        .clear   (irqTaken[gi]),
        .pending (pendRaw[gi])
      ); // RULE_13
    end
  endgenerate

  // Accumulator and index have no reset: their contents are undefined after it.
  always @(posedge clk) begin
    if (accLoad) begin
      accumulator <= resultData; // RULE_01 RULE_19
    end
    if (idxLoad) begin
      indexReg <= resultData; // RULE_02
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      fetch_address_counter <= `CPURF_PC_RESET;
    end else if (pcLoad) begin
      fetch_address_counter <= pcData; // RULE_03
    end else if (pcIncr) begin
      fetch_address_counter <= fetch_address_counter + 16'h0001; // RULE_03
    end
  end

  // The pointer simply wraps in six bits; no overflow flag exists, so deep
  // nesting silently corrupts older frames.
  always @* begin
    case (stackOp)
      `CPURF_STK_PUSH:   next_stack_ptr = stack_ptr - 6'h01; // RULE_05 RULE_08
      `CPURF_STK_PULL:   next_stack_ptr = stack_ptr + 6'h01; // RULE_05 RULE_08
      `CPURF_STK_REINIT: next_stack_ptr = `CPURF_SP_TOP; // RULE_04
      default:           next_stack_ptr = stack_ptr;
    endcase
  end

  // A call pushes two bytes and interrupt entry five, one push per cycle
  // driven by the sequencer.
  always @(posedge clk) begin
    if (reset) begin
      stack_ptr <= `CPURF_SP_TOP; // RULE_04
      stackAddr <= {`CPURF_SP_UPPER, `CPURF_SP_TOP};
    end else begin
      stack_ptr <= next_stack_ptr; // RULE_09
      stackAddr <= {`CPURF_SP_UPPER, next_stack_ptr}; // RULE_06 RULE_07
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      condition_flags_reg[`CPURF_FLAG_I] <= 1'b1;
    end else if (flagsLoad) begin
      condition_flags_reg <= flagsData; // RULE_18 RULE_10
    end else begin
      if (maskSet || intEntry) begin
        condition_flags_reg[`CPURF_FLAG_I] <= 1'b1; // RULE_18
      end else if (maskClear) begin
        condition_flags_reg[`CPURF_FLAG_I] <= 1'b0;
      end
      if (updH) begin
        condition_flags_reg[`CPURF_FLAG_H] <= halfCarry; // RULE_11
      end
      if (updNz) begin
        condition_flags_reg[`CPURF_FLAG_N] <= negative; // RULE_14
        condition_flags_reg[`CPURF_FLAG_Z] <= zero; // RULE_15
      end
      if (updC) begin
        condition_flags_reg[`CPURF_FLAG_C] <= carryOut; // RULE_16 RULE_17
      end
    end
  end

  // Service is computed from held requests so a masked one fires after unmask.
  always @(posedge clk) begin
    if (reset) begin
      irqPending <= {NI{1'b0}};
      irqService <= {NI{1'b0}};
    end else begin
      irqPending <= pendRaw & ~irqTaken;
      irqService <= (condition_flags_reg[`CPURF_FLAG_I] || maskSet || intEntry) ?
                    {NI{1'b0}} : (pendRaw & ~irqTaken); // RULE_12 RULE_13
    end
  end
endmodule // cpurf_register_file

// file: src/cpurf_defines.vh
`ifndef CPURF_DEFINES_VH
`define CPURF_DEFINES_VH
// Data and address widths.
`define CPURF_DATA_W      8
`define CPURF_ADDR_W      16
`define CPURF_SP_W        6
// Stack window: fixed upper bits and reset pointer.
`define CPURF_SP_UPPER    10'h003
`define CPURF_SP_TOP      6'h3f
// Condition flag bit positions.
`define CPURF_FLAG_C      0
`define CPURF_FLAG_Z      1
`define CPURF_FLAG_N      2
`define CPURF_FLAG_I      3
`define CPURF_FLAG_H      4
`define CPURF_FLAGS_W     5
// Stack operation codes.
`define CPURF_STK_NONE    2'h0
`define CPURF_STK_PUSH    2'h1
`define CPURF_STK_PULL    2'h2
`define CPURF_STK_REINIT  2'h3
// Number of maskable interrupt sources.
`define CPURF_IRQ_N       4
// Program counter reset value.
`define CPURF_PC_RESET    16'h0000
`endif

// file: src/cpurf_pend_latch.v
`timescale 1ns/100ps
`include "cpurf_defines.vh"
// Holds one interrupt request until it is taken; a new request wins over the clear.
module cpurf_pend_latch (
  input  wire clk,     // Core clock.
  input  wire reset,   // Synchronous reset.
  input  wire request, // Request pulse or level.
  input  wire clear,   // Taken acknowledge.
  output reg  pending  // Held request.
);
  always @(posedge clk) begin
    if (reset) begin
      pending <= 1'b0;
    end else if (request) begin
      pending <= 1'b1;
    end else if (clear) begin
      pending <= 1'b0;
    end
  end
endmodule // cpurf_pend_latch

// file: src/cpurf_flag_calc.v
`timescale 1ns/100ps
`include "cpurf_defines.vh"
// Computes the result flags for one arithmetic or logic result.
module cpurf_flag_calc #(
  parameter W = 8
) (
  input  wire [W-1:0] opA,      // First operand.
  input  wire [W-1:0] opB,      // Second operand.
  input  wire         carryIn,  // Carry in for add-with-carry.
  input  wire [W-1:0] result,   // Result from the arithmetic unit.
  output wire         halfCarry,// Carry from bit 3 into bit 4.
  output wire         negative, // Result sign.
  output wire         zero      // Result is zero.
);
  wire [4:0] lowSum;
  assign lowSum    = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
  assign halfCarry = lowSum[4];
  assign negative  = result[W-1];
  assign zero      = (result == {W{1'b0}});
endmodule // cpurf_flag_calc

// file: tb/cpurf_alu_model.sv
`timescale 1ns/100ps
// Arithmetic unit stand-in; it only adds, which is all the flag tests need.
module cpurf_alu_model (
  input  wire logic [7:0] opA,      // Operand A.
  input  wire logic [7:0] opB,      // Operand B.
  input  wire logic       carryIn,  // Carry in.
  output wire logic [7:0] sum,      // Result byte.
  output wire logic       carryOut  // Carry out of bit 7.
);
  assign {carryOut, sum} = opA + opB + carryIn;
endmodule // cpurf_alu_model

// file: tb/cpurf_register_file_chk.sv
`timescale 1ns/100ps
module cpurf_register_file_chk (
  input wire logic        clk,                   // Core clock.
  input wire logic        reset,                 // Synchronous reset.
  input wire logic [1:0]  stackOp,               // Stack operation.
  input wire logic [15:0] stackAddr,             // Stack address.
  input wire logic        accLoad,               // Accumulator load.
  input wire logic [7:0]  resultData,            // Result byte.
  input wire logic [7:0]  accumulator,           // Accumulator.
  input wire logic        pcLoad,                // Fetch address load.
  input wire logic [15:0] pcData,                // New fetch address.
  input wire logic [15:0] fetch_address_counter, // Fetch address.
  input wire logic        flagsLoad,             // Flag restore.
  input wire logic [4:0]  flagsData,             // Restored flags.
  input wire logic        updC,                  // Carry update.
  input wire logic        carryOut,              // Carry out.
  input wire logic        intEntry,              // Interrupt entry.
  input wire logic [4:0]  condition_flags_reg,   // Flags.
  input wire logic [3:0]  irqService             // Serviced requests.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_push_pull;
    stackOp == 2'h1 ##1 stackOp == 2'h2;
  endsequence
  stack_upper_a: assert property (stackAddr[15:6] == 10'h003)
    else $error("stack upper bits wrong");
  push_dec_a: assert property (stackOp == 2'h1 |=>
    stackAddr[5:0] == $past(stackAddr[5:0]) - 6'h01) else $error("push did not decrement");
  push_pull_a: assert property (s_push_pull |=> stackAddr == $past(stackAddr, 2))
    else $error("push then pull not restored");
  reinit_top_a: assert property (stackOp == 2'h3 |=> stackAddr == 16'h00ff)
    else $error("reinit not at top");
  acc_load_a: assert property (accLoad |=> accumulator == $past(resultData))
    else $error("accumulator load wrong");
  pc_load_a: assert property (pcLoad |=> fetch_address_counter == $past(pcData))
    else $error("fetch address load wrong");
  carry_upd_a: assert property (updC && !flagsLoad |=>
    condition_flags_reg[0] == $past(carryOut)) else $error("carry not updated");
  flag_restore_a: assert property (flagsLoad |=> condition_flags_reg == $past(flagsData))
    else $error("flags not restored");
  entry_mask_a: assert property (intEntry && !flagsLoad |=> condition_flags_reg[3])
    else $error("entry left mask clear");
  irq_block_a: assert property (condition_flags_reg[3] && $past(condition_flags_reg[3])
    |-> irqService == 4'h0) else $error("masked request serviced");
endmodule // cpurf_register_file_chk
bind cpurf_register_file cpurf_register_file_chk u_chk (.*);

// file: tb/cpurf_register_file_tb.sv
`timescale 1ns/100ps
module cpurf_register_file_tb;
  logic clk = 0, reset = 1, aluSel, carryOut, accLoad, idxLoad, pcLoad, pcIncr, flagsLoad;
  logic updNz, updH, updC, maskSet, maskClear, intEntry;
  logic [1:0] stackOp;
  logic [3:0] irqReq, irqTaken, irqPending, irqService;
  logic [4:0] flagsData, condition_flags_reg;
  logic [5:0] sp;
  logic [7:0] opA, opB, dataIn, aluSum, accumulator, indexReg;
  logic [15:0] pcData, stackAddr, fetch_address_counter;
  logic [28:0] addTab [3] = '{29'h11108f81, 29'h14807f00, 29'h1300ff01};
  int err_total = 0, comparisons = 0, i;
  wire logic [7:0] resultData = aluSel ? aluSum : dataIn;
  always #50 clk = ~clk;
  cpurf_alu_model alu (.opA(opA), .opB(opB), .carryIn(condition_flags_reg[0]), .sum(aluSum),
    .carryOut(carryOut));
  cpurf_register_file dut (.*);
  task chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task idle;
    @(posedge clk);
    {aluSel, accLoad, idxLoad, pcLoad, pcIncr, stackOp, flagsLoad, updNz, updH, updC, maskSet,
      maskClear, intEntry, irqReq, irqTaken} <= '0;
    #1;
  endtask
  task stk(input logic [1:0] op, input int n);
    repeat (n) begin
      @(posedge clk) stackOp <= op;
      @(posedge clk) stackOp <= 2'h0;
      #1 sp = (op == 2'h1) ? sp - 6'h01 : (op == 2'h2) ? sp + 6'h01 : 6'h3f;
      chk(stackAddr, {10'h003, sp});
    end
  endtask
  task give_verdict;
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {aluSel, accLoad, idxLoad, pcLoad, pcIncr, stackOp, flagsLoad, updNz, updH, updC, maskSet,
      maskClear, intEntry, irqReq, irqTaken, opA, opB, dataIn, pcData, flagsData} = '0;
    sp = 6'h3f;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    #1 chk(stackAddr, 16'h00ff);
    chk(fetch_address_counter, 16'h0000);
    chk({irqService, condition_flags_reg[3]}, 16'h0001);
    stk(2'h1, 65);
    stk(2'h2, 2);
    stk(2'h3, 1);
    stk(2'h1, 5);
    @(posedge clk) stackOp <= 2'h1;
    @(posedge clk) stackOp <= 2'h2;
    @(posedge clk) begin accLoad <= 1; dataIn <= 8'ha5; stackOp <= 2'h0; end
    @(posedge clk) begin accLoad <= 0; idxLoad <= 1; dataIn <= 8'h5a; end
    idle;
    chk({accumulator, indexReg}, 16'ha55a);
    @(posedge clk) begin pcLoad <= 1; pcIncr <= 1; pcData <= 16'hfffe; end
    @(posedge clk) pcLoad <= 0;
    idle;
    chk(fetch_address_counter, 16'hffff);
    @(posedge clk) begin flagsLoad <= 1; flagsData <= 5'h00; end
    idle;
    chk(condition_flags_reg, 16'h0000);
    for (i = 0; i < 3; i++) begin
      @(posedge clk) begin
        {opA, opB} <= addTab[i][15:0];
        {aluSel, accLoad, updNz, updH, updC} <= 5'h1f;
      end
      idle;
      chk({condition_flags_reg, accumulator}, addTab[i][28:16]);
    end
    @(posedge clk) irqReq <= 4'h2;
    idle;
    idle;
    chk({irqPending, irqService}, 16'h0022);
    @(posedge clk) irqTaken <= 4'h2;
    idle;
    chk({irqPending, irqService}, 16'h0000);
    @(posedge clk) begin intEntry <= 1; irqReq <= 4'h8; end
    idle;
    idle;
    chk({condition_flags_reg[3], irqPending, irqService}, 16'h0180);
    @(posedge clk) maskClear <= 1;
    idle;
    idle;
    chk({condition_flags_reg[3], irqPending, irqService}, 16'h0088);
    give_verdict;
  end
  initial begin
    #(2000 * 100);
    err_total++;
    give_verdict;
  end
endmodule // cpurf_register_file_tb
